// ---- hdl/measure_timer_pkg.sv ----
// Constants for the signal measurement timer: register offsets, field positions,
// reset values, clock source and operating mode codes.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per aligned word.
package measure_timer_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 24;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL_ZERO = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_SELECT = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_PERIOD_LIMIT = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_WIDTH_LATCH = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_PERIOD_LATCH = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 6'h20;

    // Control register zero fields.
    localparam int PRESCALE_LSB = 0;
    localparam int HALT_BIT = 2;
    localparam int WINDOW_POL_BIT = 3;
    localparam int SIGNAL_POL_BIT = 4;
    localparam int CLOCK_POL_BIT = 5;
    localparam int SHORT_MODE_BIT = 6;

    // Control register one fields.
    localparam int RUN_BIT = 0;
    localparam int REPEAT_BIT = 1;
    localparam int MODE_LSB = 8;

    // Status register fields.
    localparam int COUNT_CLEAR_BIT = 0;
    localparam int WIDTH_UPDATE_BIT = 1;
    localparam int PERIOD_UPDATE_BIT = 2;
    localparam int WINDOW_LEVEL_BIT = 8;
    localparam int SIGNAL_LEVEL_BIT = 9;
    localparam int RUN_STATE_BIT = 10;

    // Flag register fields: flags in the low bits, their enables from ENABLE_LSB.
    localparam int WIDTH_FLAG_BIT = 0;
    localparam int PERIOD_FLAG_BIT = 1;
    localparam int MATCH_FLAG_BIT = 2;
    localparam int ENABLE_LSB = 8;

    // Reset and load values.
    localparam logic [COUNT_W-1:0] COUNT_RST = 24'h00_0000;
    localparam logic [COUNT_W-1:0] LIMIT_RST = 24'hff_ffff;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h00_0001;

    // Clock source codes.
    localparam logic [2:0] SRC_SYSTEM = 3'h0;
    localparam logic [2:0] SRC_SYSTEM_DIV4 = 3'h1;
    localparam logic [2:0] SRC_FAST_OSC = 3'h2;
    localparam logic [2:0] SRC_SLOW_OSC = 3'h3;
    localparam logic [2:0] SRC_MID_OSC = 3'h4;

    // Operating mode codes.
    localparam logic [3:0] MODE_TIMER = 4'h0;
    localparam logic [3:0] MODE_GATED_TIMER = 4'h1;
    localparam logic [3:0] MODE_PERIOD_DUTY = 4'h2;
    localparam logic [3:0] MODE_HIGH_LOW = 4'h3;
    localparam logic [3:0] MODE_WINDOW_MEASURE = 4'h4;
    localparam logic [3:0] MODE_GATED_WINDOW = 4'h5;
    localparam logic [3:0] MODE_TIME_OF_FLIGHT = 4'h6;
    localparam logic [3:0] MODE_CAPTURE = 4'h7;
    localparam logic [3:0] MODE_COUNTER = 4'h8;
    localparam logic [3:0] MODE_GATED_COUNTER = 4'h9;
    localparam logic [3:0] MODE_WINDOWED_COUNTER = 4'ha;

endpackage

// ---- hdl/signal_measurement_timer.sv ----
// Signal measurement timer: 24-bit counter with prescaled clock sources, width and
// period latches, period match, halt at match, input polarity and live status.
// Assumes an Avalon-MM master on mclk; oscillator, signal and window pins are asynchronous.

`timescale 1ns/1ps
`default_nettype none

module signal_measurement_timer
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [measure_timer_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [measure_timer_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [measure_timer_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fast_internal_osc,
    input wire logic slow_internal_osc,
    input wire logic mid_internal_osc,
    input wire logic measured_signal,
    input wire logic window_input,
    output logic width_acq_req,
    output logic period_acq_req,
    output logic match_req
);
    import measure_timer_pkg::*;

    // All state lives in one struct; no global state, so instances stay independent.
    typedef struct packed {
        logic [2:0] osc_m;
        logic [2:0] osc_s;
        logic [2:0] osc_d;
        logic sig_m;
        logic sig_s;
        logic win_m;
        logic win_s;
        logic [1:0] div4;
        logic [2:0] pre;
        logic sig_t;
        logic sig_p;
        logic win_t;
        logic win_p;
        logic run_t;
        logic armed;
        logic [7:0] ctrl0;
        logic run_request;
        logic repeat_acq;
        logic [3:0] mode;
        logic [2:0] clock_source_field;
        logic [COUNT_W-1:0] measure_count;
        logic [COUNT_W-1:0] period_limit;
        logic [COUNT_W-1:0] width_latch;
        logic [COUNT_W-1:0] period_latch;
        logic [2:0] flags;
        logic [2:0] flag_en;
        logic ack;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t r;
    state_t n;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb
    begin
        logic [2:0] osc_edge;
        logic src_tick;
        logic [2:0] mask;
        logic tick;
        logic samp;
        logic go;
        logic s_rise;
        logic s_fall;
        logic w_rise;
        logic w_fall;
        logic inc;
        logic cap_w;
        logic cap_p;
        logic clr;
        logic load_one;
        logic done;
        logic arm_set;
        logic arm_clr;
        logic short_mode;
        logic halt;
        logic match;
        logic [COUNT_W-1:0] count_inc;
        logic [COUNT_W-1:0] count_view;
        logic [2:0] flag_set;
        logic [2:0] flag_clr;
        logic [31:0] m;
        logic wr;
        n = r;
        short_mode = r.ctrl0[SHORT_MODE_BIT];
        halt = r.ctrl0[HALT_BIT];
        flag_set = 3'h0;
        flag_clr = 3'h0;

        // Two flip-flops on every oscillator, signal and window pin before any logic looks at it.
        n.osc_m = {mid_internal_osc, slow_internal_osc, fast_internal_osc};
        n.osc_s = r.osc_m;
        n.osc_d = r.osc_s;
        n.sig_m = measured_signal;
        n.sig_s = r.sig_m;
        n.win_m = window_input;
        n.win_s = r.win_m;
        n.div4 = r.div4 + 2'd1;

        // Clock polarity picks the active edge of an oscillator source.
        osc_edge = r.ctrl0[CLOCK_POL_BIT] ? (~r.osc_s & r.osc_d) : (r.osc_s & ~r.osc_d);
        case (r.clock_source_field)
            SRC_SYSTEM: src_tick = 1'b1;
            SRC_SYSTEM_DIV4: src_tick = (r.div4 == 2'd3);
            SRC_FAST_OSC: src_tick = osc_edge[0];
            SRC_SLOW_OSC: src_tick = osc_edge[1];
            SRC_MID_OSC: src_tick = osc_edge[2];
            default: src_tick = 1'b0;
        endcase
        mask = {r.ctrl0[PRESCALE_LSB +: 2] == 2'd3, r.ctrl0[PRESCALE_LSB +: 2] >= 2'd2,
                r.ctrl0[PRESCALE_LSB +: 2] >= 2'd1};
        if (src_tick)
        begin
            n.pre = r.pre + 3'd1;
        end
        tick = src_tick && ((r.pre & mask) == mask);

        // Counter modes sample inputs every cycle; other modes on the prescaled tick,
        // which is why status bits lag there by the synchroniser and tick delay.
        samp = r.mode[3] || tick;
        if (samp)
        begin
            n.sig_t = r.sig_s ^ r.ctrl0[SIGNAL_POL_BIT];
            n.sig_p = r.sig_t;
            n.win_t = r.win_s ^ r.ctrl0[WINDOW_POL_BIT];
            n.win_p = r.win_t;
            n.run_t = r.run_request;
        end
        go = r.run_t;
        s_rise = samp && go && r.sig_t && !r.sig_p;
        s_fall = samp && go && !r.sig_t && r.sig_p;
        w_rise = samp && go && r.win_t && !r.win_p;
        w_fall = samp && go && !r.win_t && r.win_p;

        inc = 1'b0;
        cap_w = 1'b0;
        cap_p = 1'b0;
        clr = 1'b0;
        load_one = 1'b0;
        done = 1'b0;
        arm_set = 1'b0;
        arm_clr = 1'b0;
        case (r.mode)
            MODE_TIMER:
            begin
                inc = tick && go;
            end
            MODE_GATED_TIMER:
            begin
                inc = tick && go && r.sig_t;
                cap_w = s_fall;
            end
            MODE_PERIOD_DUTY:
            begin
                inc = tick && go;
                cap_w = s_fall;
                cap_p = s_rise;
                load_one = s_rise;
                done = s_rise;
            end
            MODE_HIGH_LOW:
            begin
                inc = tick && go && r.armed;
                arm_set = s_rise;
                cap_w = s_fall && r.armed;
                cap_p = s_rise && r.armed;
                clr = cap_w || cap_p;
                done = cap_p;
            end
            MODE_WINDOW_MEASURE, MODE_GATED_WINDOW:
            begin
                inc = tick && go && r.armed && (r.mode == MODE_WINDOW_MEASURE || r.sig_t);
                arm_set = w_rise;
                cap_p = w_rise && r.armed;
                clr = cap_p;
                done = cap_p;
            end
            MODE_TIME_OF_FLIGHT:
            begin
                inc = tick && go && r.armed;
                arm_set = w_rise;
                cap_w = w_rise && r.armed;
                cap_p = s_rise && r.armed;
                arm_clr = cap_p;
                clr = cap_w || cap_p;
                done = cap_p;
            end
            MODE_CAPTURE:
            begin
                inc = tick && go;
                cap_p = w_rise;
                cap_w = w_fall;
                done = w_rise;
            end
            MODE_COUNTER, MODE_GATED_COUNTER:
            begin
                inc = s_rise && (r.mode == MODE_COUNTER || r.win_t);
                cap_w = w_fall;
                done = w_fall;
            end
            MODE_WINDOWED_COUNTER:
            begin
                inc = s_rise && r.armed;
                arm_set = w_rise;
                cap_w = w_fall && r.armed;
                cap_p = w_rise && r.armed;
                done = cap_p;
            end
            default:
            begin
                inc = 1'b0;
            end
        endcase
        if (!go || arm_clr)
        begin
            n.armed = 1'b0;
        end
        else if (arm_set)
        begin
            n.armed = 1'b1;
        end

        // 16-bit operation counts and compares only the low half.
        match = short_mode ? (r.measure_count[15:0] == r.period_limit[15:0])
                           : (r.measure_count == r.period_limit);
        count_inc = short_mode ? {8'h00, r.measure_count[15:0] + 16'h0001}
                               : r.measure_count + COUNT_ONE;
        count_view = short_mode ? {8'h00, r.measure_count[15:0]} : r.measure_count;
        if (clr)
        begin
            n.measure_count = COUNT_RST;
        end
        else if (load_one)
        begin
            n.measure_count = COUNT_ONE;
        end
        else if (inc && match)
        begin
            flag_set[MATCH_FLAG_BIT] = 1'b1;
            if (!halt)
            begin
                n.measure_count = COUNT_RST;
            end
        end
        else if (inc)
        begin
            n.measure_count = count_inc;
        end
        // A halted counter sitting on the limit keeps the match raised.
        if (halt && match && go)
        begin
            flag_set[MATCH_FLAG_BIT] = 1'b1;
        end
        if (cap_w)
        begin
            n.width_latch = count_view;
            flag_set[WIDTH_FLAG_BIT] = 1'b1;
        end
        if (cap_p)
        begin
            n.period_latch = count_view;
            flag_set[PERIOD_FLAG_BIT] = 1'b1;
        end
        if (done && !r.repeat_acq)
        begin
            n.run_request = 1'b0;
        end

        // Bus slave: one wait cycle, then the answer; writes land on the answer edge.
        n.ack = (avs_read || avs_write) && !r.ack;
        wr = avs_write && r.ack;
        m = 32'h0000_0000;
        if (avs_read && !r.ack)
        begin
            case (avs_address)
                OFS_CTRL_ZERO: n.rdata = {24'h00_0000, r.ctrl0};
                OFS_CTRL_ONE: n.rdata = {20'h0_0000, r.mode, 6'h00, r.repeat_acq, r.run_request};
                OFS_STATUS: n.rdata = {21'h00_0000, r.run_t, r.sig_t, r.win_t, 8'h00};
                OFS_CLOCK_SELECT: n.rdata = {29'h0000_0000, r.clock_source_field};
                OFS_COUNT: n.rdata = {8'h00, count_view};
                OFS_PERIOD_LIMIT: n.rdata = {8'h00, r.period_limit};
                OFS_WIDTH_LATCH: n.rdata = {8'h00, r.width_latch};
                OFS_PERIOD_LATCH: n.rdata = {8'h00, r.period_latch};
                OFS_FLAGS: n.rdata = {21'h00_0000, r.flag_en, 5'h00, r.flags};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
        if (wr)
        begin
            case (avs_address)
                OFS_CTRL_ZERO:
                begin
                    m = merge({24'h00_0000, r.ctrl0}, avs_writedata, avs_byteenable);
                    n.ctrl0 = m[7:0];
                end
                OFS_CTRL_ONE:
                begin
                    m = merge({20'h0_0000, r.mode, 6'h00, r.repeat_acq, r.run_request},
                              avs_writedata, avs_byteenable);
                    n.run_request = m[RUN_BIT];
                    n.repeat_acq = m[REPEAT_BIT];
                    n.mode = m[MODE_LSB +: 4];
                end
                OFS_STATUS:
                begin
                    m = merge(32'h0000_0000, avs_writedata, avs_byteenable);
                    if (m[COUNT_CLEAR_BIT])
                    begin
                        n.measure_count = COUNT_RST;
                    end
                    if (m[WIDTH_UPDATE_BIT])
                    begin
                        n.width_latch = count_view;
                        flag_set[WIDTH_FLAG_BIT] = 1'b1;
                    end
                    if (m[PERIOD_UPDATE_BIT])
                    begin
                        n.period_latch = count_view;
                        flag_set[PERIOD_FLAG_BIT] = 1'b1;
                    end
                end
                OFS_CLOCK_SELECT:
                begin
                    m = merge({29'h0000_0000, r.clock_source_field}, avs_writedata, avs_byteenable);
                    n.clock_source_field = m[2:0];
                end
                OFS_COUNT:
                begin
                    m = merge({8'h00, r.measure_count}, avs_writedata, avs_byteenable);
                    n.measure_count = m[COUNT_W-1:0];
                end
                OFS_PERIOD_LIMIT:
                begin
                    m = merge({8'h00, r.period_limit}, avs_writedata, avs_byteenable);
                    n.period_limit = m[COUNT_W-1:0];
                end
                OFS_WIDTH_LATCH:
                begin
                    m = merge({8'h00, r.width_latch}, avs_writedata, avs_byteenable);
                    n.width_latch = m[COUNT_W-1:0];
                end
                OFS_PERIOD_LATCH:
                begin
                    m = merge({8'h00, r.period_latch}, avs_writedata, avs_byteenable);
                    n.period_latch = m[COUNT_W-1:0];
                end
                OFS_FLAGS:
                begin
                    m = merge(32'h0000_0000, avs_writedata, avs_byteenable);
                    flag_clr = m[2:0];
                    n.flag_en = m[ENABLE_LSB +: 3];
                end
                default:
                begin
                    m = 32'h0000_0000;
                end
            endcase
        end
        // A hardware event in the same cycle as its clear is kept.
        n.flags = (r.flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            r <= '0;
            r.period_limit <= LIMIT_RST;
        end
        else
        begin
            r <= n;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
    assign avs_readdata = r.rdata;
    assign width_acq_req = r.flags[WIDTH_FLAG_BIT] && r.flag_en[WIDTH_FLAG_BIT];
    assign period_acq_req = r.flags[PERIOD_FLAG_BIT] && r.flag_en[PERIOD_FLAG_BIT];
    assign match_req = r.flags[MATCH_FLAG_BIT] && r.flag_en[MATCH_FLAG_BIT];

endmodule // signal_measurement_timer

`default_nettype wire

// ---- bench/pulse_source.sv ----
// Far-side model: drives the measured signal and the window input.
// Assumes the bench steps it from mclk; it holds a level or toggles a square wave.
`timescale 1ns/1ps
`default_nettype none
module pulse_source
(
    input wire logic mclk,
    input wire logic run,
    input wire logic lvl,
    output logic measured_signal,
    output logic window_input
);
    int cnt;
    initial
    begin
        cnt = 0;
        measured_signal = 1'b0;
        window_input = 1'b0;
    end
    // A 12-cycle square wave keeps every edge far apart from the synchroniser depth.
    always @(posedge mclk)
    begin
        cnt <= (cnt == 5) ? 0 : cnt + 1;
        if (!run)
        begin
            measured_signal <= lvl;
            window_input <= lvl;
        end
        else if (cnt == 5)
            measured_signal <= ~measured_signal;
    end
endmodule // pulse_source
`default_nettype wire

// ---- bench/measure_timer_checker.sv ----
// Checker for the measurement timer: bus answer, readback and request gating.
// Assumes it is bound to each instance of the timer top module.
`timescale 1ns/1ps
`default_nettype none
module measure_timer_checker
    import measure_timer_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic fast_internal_osc,
    input wire logic slow_internal_osc,
    input wire logic mid_internal_osc,
    input wire logic measured_signal,
    input wire logic window_input,
    input wire logic width_acq_req,
    input wire logic period_acq_req,
    input wire logic match_req
);
    typedef struct packed {logic sh; logic [2:0] en; logic [23:0] lim;} shadow_t;
    shadow_t s_r;
    shadow_t s_nxt;
    logic wr_done;
    logic rd_done;
    assign wr_done = avs_write & ~avs_waitrequest;
    assign rd_done = avs_read & ~avs_waitrequest;
    always_comb
    begin
        s_nxt = s_r;
        if (wr_done && avs_address == OFS_CTRL_ZERO && avs_byteenable[0])
            s_nxt.sh = avs_writedata[SHORT_MODE_BIT];
        if (wr_done && avs_address == OFS_FLAGS && avs_byteenable[1])
            s_nxt.en = avs_writedata[ENABLE_LSB+:3];
        for (int i = 0; i < 3; i++)
            if (wr_done && avs_address == OFS_PERIOD_LIMIT && avs_byteenable[i])
                s_nxt.lim[8*i+:8] = avs_writedata[8*i+:8];
    end
    always_ff @(posedge mclk)
        if (srst)
            s_r <= '{sh: 1'b0, en: 3'h0, lim: LIMIT_RST};
        else
            s_r <= s_nxt;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait state");
    AST_UPPER_ZERO: assert property (rd_done && avs_address >= OFS_COUNT && avs_address <= OFS_PERIOD_LATCH |-> avs_readdata[31:24] == 8'h00)
        else $error("24-bit register read with top byte set");
    AST_SHORT_UPPER: assert property (rd_done && s_r.sh && (avs_address == OFS_COUNT || avs_address == OFS_WIDTH_LATCH) |-> avs_readdata[23:16] == 8'h00)
        else $error("short mode read with upper byte set");
    AST_CMD_READ_ZERO: assert property (rd_done && avs_address == OFS_STATUS |-> avs_readdata[2:0] == 3'h0)
        else $error("command bits read back nonzero");
    AST_LIMIT_READBACK: assert property (rd_done && !s_r.sh && avs_address == OFS_PERIOD_LIMIT |-> avs_readdata[23:0] == s_r.lim)
        else $error("period limit read differs from written value");
    AST_WIDTH_REQ_EN: assert property (width_acq_req |-> s_r.en[0])
        else $error("width request without its enable");
    AST_PERIOD_REQ_EN: assert property (period_acq_req |-> s_r.en[1])
        else $error("period request without its enable");
    AST_MATCH_REQ_EN: assert property (match_req |-> s_r.en[2])
        else $error("match request without its enable");
    AST_MATCH_HOLD: assert property (match_req && !(avs_write && avs_address == OFS_FLAGS) |=> match_req)
        else $error("match request dropped without a flag write");
endmodule // measure_timer_checker
bind signal_measurement_timer measure_timer_checker u_measure_timer_checker (.mclk, .srst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .fast_internal_osc, .slow_internal_osc, .mid_internal_osc,
    .measured_signal, .window_input, .width_acq_req, .period_acq_req, .match_req);
`default_nettype wire

// ---- bench/signal_measurement_timer_tb_top.sv ----
// Testbench for the measurement timer, with a register model kept in a table.
// Assumes the checker is bound to the design and the pulse source drives its pins.
`timescale 1ns/1ps
`default_nettype none
module signal_measurement_timer_tb_top import measure_timer_pkg::*;;
    logic mclk, srst, avs_read, avs_write, sig, win, wreq, preq, mreq, prun, plvl, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    int cyc, n_fail, n_tests;
    logic [31:0] mdl [int];
    int rate [9] = '{512, 128, 128, 16, 32, 0, 256, 128, 64};
    signal_measurement_timer u_signal_measurement_timer (.mclk(mclk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fast_internal_osc(cyc[1]), .slow_internal_osc(cyc[4]), .mid_internal_osc(cyc[3]),
        .measured_signal(sig), .window_input(win), .width_acq_req(wreq),
        .period_acq_req(preq), .match_req(mreq));
    pulse_source u_pulse_source (.mclk(mclk), .run(prun), .lvl(plvl),
        .measured_signal(sig), .window_input(win));
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // The oscillator pins come from this counter, so it also paces the clock sources.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waitrequest is sampled at each rising edge; the edge that sees it low is the answer edge.
    task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        do
            @(posedge mclk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (w && mdl.exists(a))
            for (int i = 0; i < 4; i++)
                if (be[i])
                    mdl[a][8*i+:8] = d[8*i+:8];
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
        bus(1, a, d, be);
    endtask
    task automatic rd(input logic [5:0] a);
        bus(0, a, 32'h0000_0000, 4'hf);
    endtask
    function automatic logic [31:0] msk(input logic [5:0] a);
        return (a == 0) ? 32'h0000_007f : (a == 4) ? 32'h0000_0f03 : (a == 12) ? 32'h0000_0007 : 32'h00ff_ffff;
    endfunction
    initial
    begin
        {srst, avs_read, avs_write, prun, plvl} = 5'b10000;
        {avs_address, avs_writedata, avs_byteenable, cyc, n_fail, n_tests} = '0;
        foreach (rate[i])
            if (i < 8)
                mdl[i * 4] = 32'h0000_0000;
        mdl.delete(8);
        mdl[20] = 32'h00ff_ffff;
        void'($urandom(46));
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        for (int a = 0; a <= 36; a += 4)
        begin
            rd(a);
            chk(q, mdl.exists(a) ? mdl[a] & msk(a) : 0);
        end
        for (int i = 0; i < 9; i++)
        begin
            wr((i == 8) ? 36 : 16 + 4 * (i % 4), $urandom, $urandom_range(1, 15));
            rd((i == 8) ? 36 : 16 + 4 * (i % 4));
            chk(q, mdl.exists(avs_address) ? mdl[avs_address] & msk(avs_address) : 0);
        end
        wr(OFS_COUNT, 32'h0012_3456);
        wr(OFS_STATUS, 32'h0000_0002);
        rd(OFS_WIDTH_LATCH);
        chk(q, 32'h0012_3456);
        wr(OFS_STATUS, 32'h0000_0004);
        rd(OFS_PERIOD_LATCH);
        chk(q, 32'h0012_3456);
        wr(OFS_FLAGS, 32'h0000_0300);
        @(negedge mclk);
        chk({wreq, preq}, 2'b11);
        wr(OFS_FLAGS, 32'h0000_0003);
        @(negedge mclk);
        chk({wreq, preq}, 2'b00);
        wr(OFS_STATUS, 32'h0000_0001);
        rd(OFS_COUNT);
        chk(q, 32'h0000_0000);
        rd(OFS_STATUS);
        chk(q[2:0], 3'h0);
        wr(OFS_PERIOD_LIMIT, 32'h00ff_ffff);
        for (int i = 0; i < 9; i++)
        begin
            wr(OFS_CLOCK_SELECT, (i < 6) ? i : 0);
            wr(OFS_CTRL_ZERO, (i < 6) ? ((i == 2) ? 32'h0000_0020 : 0) : i - 5);
            wr(OFS_STATUS, 32'h0000_0001);
            wr(OFS_CTRL_ONE, 32'h0000_0001);
            repeat (512) @(posedge mclk);
            wr(OFS_CTRL_ONE, 32'h0000_0000);
            repeat (200) @(posedge mclk);
            rd(OFS_COUNT);
            chk(q + 6 >= rate[i] && q <= rate[i] + 6, 1);
        end
        wr(OFS_CTRL_ZERO, 32'h0000_0000);
        wr(OFS_PERIOD_LIMIT, 32'h0000_000a);
        for (int h = 0; h < 2; h++)
        begin
            wr(OFS_CTRL_ZERO, h ? 32'h0000_0004 : 32'h0000_0000);
            wr(OFS_FLAGS, 32'h0000_0404);
            wr(OFS_STATUS, 32'h0000_0001);
            wr(OFS_CTRL_ONE, 32'h0000_0001);
            repeat (50) @(posedge mclk);
            @(negedge mclk);
            chk(mreq, 1'b1);
            wr(OFS_CTRL_ONE, 32'h0000_0000);
            rd(OFS_COUNT);
            chk(h ? q : (q <= 10), h ? 32'h0000_000a : 1);
        end
        wr(OFS_FLAGS, 32'h0000_0004);
        @(negedge mclk);
        chk(mreq, 1'b0);
        wr(OFS_CTRL_ZERO, 32'h0000_0040);
        wr(OFS_COUNT, 32'h00ab_cdef);
        wr(OFS_STATUS, 32'h0000_0002);
        rd(OFS_COUNT);
        chk(q, 32'h0000_cdef);
        rd(OFS_WIDTH_LATCH);
        chk(q, 32'h0000_cdef);
        wr(OFS_PERIOD_LIMIT, 32'h00ff_ffff);
        for (int i = 0; i < 4; i++)
        begin
            plvl <= i[0];
            wr(OFS_CTRL_ZERO, i[1] ? 32'h0000_0018 : 32'h0000_0000);
            wr(OFS_CTRL_ONE, i[1] ? 32'h0000_0901 : 32'h0000_0501);
            repeat (30) @(posedge mclk);
            rd(OFS_STATUS);
            chk(q[10:8], {1'b1, {2{i[0] ^ i[1]}}});
            wr(OFS_CTRL_ONE, 32'h0000_0000);
        end
        repeat (30) @(posedge mclk);
        rd(OFS_STATUS);
        chk(q[10], 1'b0);
        wr(OFS_CTRL_ZERO, 32'h0000_0000);
        prun <= 1'b1;
        wr(OFS_FLAGS, 32'h0000_0007);
        for (int r = 0; r < 2; r++)
        begin
            wr(OFS_CTRL_ONE, r ? 32'h0000_0203 : 32'h0000_0201);
            repeat (200) @(posedge mclk);
            rd(OFS_CTRL_ONE);
            chk(q[1:0], r ? 2'b11 : 2'b00);
            rd(OFS_FLAGS);
            chk(q[1], 1'b1);
        end
        wr(OFS_CTRL_ONE, 32'h0000_0000);
        rd(OFS_PERIOD_LATCH);
        chk(q >= 11 && q <= 13, 1);
        print_verdict();
    end
endmodule // signal_measurement_timer_tb_top
`default_nettype wire
